// ===== rtl/dee_pkg.sv
/*
 package for the data nonvolatile array access block: register offsets, field
 positions, reset values and timing counts.
 assumes a 20 MHz core clock and a 32-bit classic wishbone register bus.
*/
package dee_pkg;

   // ****************************************************
   // sizes
   // ****************************************************
   localparam int unsigned DEPTH      = 1024;
   localparam int unsigned AW         = 10;
   localparam int unsigned DW         = 8;

   // ****************************************************
   // register byte offsets
   // ****************************************************
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_UNLOCK  = 8'h04;
   localparam logic [7:0] OFS_DATA    = 8'h08;
   localparam logic [7:0] OFS_ADDR_LO = 8'h0C;
   localparam logic [7:0] OFS_ADDR_HI = 8'h10;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h1C;

   // ****************************************************
   // control register fields
   // ****************************************************
   localparam int unsigned BIT_RD     = 0;
   localparam int unsigned BIT_WR     = 1;
   localparam int unsigned BIT_WRITE_PERMIT_BIT   = 2;
   localparam int unsigned BIT_WRITE_ABORT_FLAG  = 3;

   // interrupt status/enable/clear field
   localparam int unsigned BIT_DONE   = 0;

   // ****************************************************
   // unlock key sequence and reset values
   // ****************************************************
   localparam logic [7:0] KEY_FIRST   = 8'h55;
   localparam logic [7:0] KEY_SECOND  = 8'hAA;
   localparam logic [7:0] RST_BYTE    = 8'h00;

   // ****************************************************
   // timing
   // ****************************************************
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned WRITE_TIME_US = 4000;
   localparam int unsigned WRITE_CYCLES  = WRITE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TW            = 17;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ERASE = 4'b0010,
      ST_PROG  = 4'b0100,
      ST_DONE  = 4'b1000
   } dee_state_type;

endpackage

// ===== rtl/dee_mem.sv
/*
 byte-wide storage array of the nonvolatile data block, registered read data.
 assumes one access per cycle from the controller in dee_top.
*/
`timescale 1ns/10ps
module dee_mem
   import dee_pkg::*;
(
   // clock
   input  wire logic          clk_i,
   // write port
   input  wire logic          we_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] wdata_i,
   // read data
   output logic      [DW-1:0] rdata_o
);

   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] rdata_q;

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
      rdata_q <= mem_q[addr_i];
   end

   assign rdata_o = rdata_q;

endmodule // dee_mem

// ===== rtl/dee_top.sv
/*
 access logic for a 1024-byte on-chip nonvolatile data array, reached only
 through control, unlock, data and address registers on classic wishbone.
 assumes rst_i is the master clear reset, wdt_rst_i the watchdog reset, and
 por_i a power-on reset that also clears the abort flag.
*/
// Operation
// R01: single byte reads and writes via data register
// R02: 1024 bytes, ten bit address from pair
// R03: array reachable only through these registers
// R04: each write erases location before programming
// R05: internal timer sets write duration
// R06: unlock register has no storage, reads zero
// R07: start bits set by software, cleared by hardware
// R08: writes need permit bit; cleared at power-up
// R09: reset during write sets abort flag
// R10: that reset zeroes data and address registers
// R11: write done flag sticky until software clears
// R12: write starts only after unlock key writes
// R13: read fills data register, clears start bit promptly
`timescale 1ns/10ps
module dee_top
   import dee_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
)(
   // clock and resets
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wdt_rst_i,
   input  wire logic        por_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // interrupt
   output logic             irq_o
);

   // ****************************************************
   // bus decode
   // ****************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   logic req;
   logic wr_b0;
   logic rd_req;
   assign req    = cyc_i && stb_i && !ack_o;
   assign wr_b0  = req && we_i && sel_i[0];
   assign rd_req = req && !we_i;

   // ****************************************************
   // state
   // ****************************************************
   dee_state_type  st_q, st_d;
   logic [TW-1:0]  tmr_q, tmr_d;
   logic           rd_q, rd_d;
   logic           wr_q, wr_d;
   logic           write_permit_bit_q, write_permit_bit_d;
   logic           write_abort_flag_q, write_abort_flag_d;
   logic [DW-1:0]  data_q, data_d;
   logic [7:0]     alo_q, alo_d;
   logic [1:0]     ahi_q, ahi_d;
   logic [1:0]     key_q, key_d;
   logic           done_q, done_d;
   logic           ien_q, ien_d;
   logic           ack_q, ack_d;
   logic [31:0]    dat_q, dat_d;
   logic           rd_wait_q, rd_wait_d;
   logic           mem_we;
   logic           wr_go;
   logic [DW-1:0]  mem_wd;
   logic [DW-1:0]  mem_rd;
   logic [AW-1:0]  addr;
   logic           any_rst;

   assign addr    = {ahi_q, alo_q}; // [R02]
   assign any_rst = rst_i || wdt_rst_i;

   // array sits behind the registers only, never on the bus directly
   dee_mem u_mem ( // [R03]
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .addr_i  (addr),
      .wdata_i (mem_wd),
      .rdata_o (mem_rd)
   );

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      rd_d      = rd_q;
      wr_d      = wr_q;
      write_permit_bit_d    = write_permit_bit_q;
      write_abort_flag_d   = write_abort_flag_q;
      data_d    = data_q;
      alo_d     = alo_q;
      ahi_d     = ahi_q;
      done_d    = done_q;
      ien_d     = ien_q;
      rd_wait_d = 1'b0;
      wr_go     = 1'b0;

      // read completes one cycle after start: registered array output
      if (rd_wait_q) begin
         data_d = mem_rd; // [R01] [R13]
         rd_d   = 1'b0;   // [R07]
      end

      // engine finished: release the start bit and raise the flag
      if (st_q == ST_DONE) begin
         wr_d   = 1'b0; // [R07]
         done_d = 1'b1; // [R11]
      end

      if (wr_b0) begin
         if (hit(adr_i, OFS_CTRL)) begin
            write_permit_bit_d = dat_i[BIT_WRITE_PERMIT_BIT]; // [R08]
            if (!dat_i[BIT_WRITE_ABORT_FLAG]) begin
               write_abort_flag_d = 1'b0;
            end
            // start bits set only; a busy engine ignores a second start
            if (dat_i[BIT_RD] && !rd_q && !wr_q) begin // [R07]
               rd_d      = 1'b1;
               rd_wait_d = 1'b1;
            end else if (dat_i[BIT_WR] && !wr_q && !rd_q && write_permit_bit_q
                         && key_q == 2'b10) begin // [R08] [R12]
               wr_d  = 1'b1;
               wr_go = 1'b1;
            end
         end else if (hit(adr_i, OFS_DATA) && !wr_q) begin
            data_d = dat_i[7:0]; // [R01]
         end else if (hit(adr_i, OFS_ADDR_LO) && !wr_q) begin
            alo_d = dat_i[7:0];
         end else if (hit(adr_i, OFS_ADDR_HI) && !wr_q) begin
            ahi_d = dat_i[1:0];
         end else if (hit(adr_i, OFS_IRQ_CLR) && dat_i[BIT_DONE]) begin
            done_d = done_q && st_q == ST_DONE; // [R11]
            if (st_q == ST_DONE) begin
               done_d = 1'b1;
            end
         end else if (hit(adr_i, OFS_IRQ_EN)) begin
            ien_d = dat_i[BIT_DONE];
         end
      end

   end

   // ****************************************************
   // unlock key tracker
   // ****************************************************
   // any other register write in between breaks the sequence
   always_comb begin
      key_d = key_q;
      if (wr_b0) begin
         key_d = 2'b00;
         if (hit(adr_i, OFS_UNLOCK)) begin
            if (dat_i[7:0] == KEY_FIRST) begin
               key_d = 2'b01;
            end else if (dat_i[7:0] == KEY_SECOND && key_q == 2'b01) begin
               key_d = 2'b10; // [R12]
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (por_i || any_rst) begin
         key_q <= 2'b00;
      end else begin
         key_q <= key_d;
      end
   end

   // ****************************************************
   // write engine: erase, then timed program
   // ****************************************************
   always_comb begin
      st_d   = st_q;
      tmr_d  = tmr_q;
      mem_we = 1'b0;
      mem_wd = data_q;
      unique case (st_q)
         ST_IDLE: begin
            if (wr_go) begin
               tmr_d = '0;
               st_d  = ST_ERASE;
            end
         end
         ST_ERASE: begin
            mem_we = 1'b1;       // [R04]
            mem_wd = 8'hFF;
            st_d   = ST_PROG;
         end
         ST_PROG: begin
            if (tmr_q == TW'(WRITE_CYCLES_P - 1)) begin // [R05]
               mem_we = 1'b1;
               st_d   = ST_DONE;
            end else begin
               tmr_d = tmr_q + TW'(1);
            end
         end
         ST_DONE: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // a reset mid-write drops the engine back to idle; the byte is lost
   always_ff @(posedge clk_i) begin
      if (por_i || any_rst) begin
         st_q  <= ST_IDLE;
         tmr_q <= '0;
      end else begin
         st_q  <= st_d;
         tmr_q <= tmr_d;
      end
   end

   // ****************************************************
   // bus answer: registered ack and read data
   // ****************************************************
   always_comb begin
      ack_d = req;
      dat_d = 32'h0000_0000;
      if (rd_req) begin
         if (hit(adr_i, OFS_CTRL)) begin
            dat_d = {28'h0000000, write_abort_flag_q, write_permit_bit_q, wr_q, rd_q};
         end else if (hit(adr_i, OFS_DATA)) begin
            dat_d = {24'h000000, data_q};
         end else if (hit(adr_i, OFS_ADDR_LO)) begin
            dat_d = {24'h000000, alo_q};
         end else if (hit(adr_i, OFS_ADDR_HI)) begin
            dat_d = {30'h0, ahi_q};
         end else if (hit(adr_i, OFS_IRQ_ST)) begin
            dat_d = {31'h0, done_q};
         end else if (hit(adr_i, OFS_IRQ_EN)) begin
            dat_d = {31'h0, ien_q};
         end else begin
            dat_d = 32'h0000_0000; // [R06]
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (por_i || any_rst) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   // ****************************************************
   // registers
   // ****************************************************
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         rd_q      <= 1'b0;
         wr_q      <= 1'b0;
         write_permit_bit_q    <= 1'b0; // [R08]
         write_abort_flag_q   <= 1'b0;
         data_q    <= RST_BYTE;
         alo_q     <= RST_BYTE;
         ahi_q     <= 2'b00;
         done_q    <= 1'b0;
         ien_q     <= 1'b0;
         rd_wait_q <= 1'b0;
      end else if (any_rst) begin
         // an interrupted write is flagged; the partial byte is lost
         write_abort_flag_q   <= write_abort_flag_q || wr_q; // [R09]
         rd_q      <= 1'b0;
         wr_q      <= 1'b0;
         write_permit_bit_q    <= 1'b0;
         data_q    <= RST_BYTE; // [R10]
         alo_q     <= RST_BYTE; // [R10]
         ahi_q     <= 2'b00;
         done_q    <= 1'b0;
         ien_q     <= 1'b0;
         rd_wait_q <= 1'b0;
      end else begin
         rd_q      <= rd_d;
         wr_q      <= wr_d;
         write_permit_bit_q    <= write_permit_bit_d;
         write_abort_flag_q   <= write_abort_flag_d;
         data_q    <= data_d;
         alo_q     <= alo_d;
         ahi_q     <= ahi_d;
         done_q    <= done_d;
         ien_q     <= ien_d;
         rd_wait_q <= rd_wait_d;
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;
   assign irq_o = done_q && ien_q; // [R11]

endmodule // dee_top

// ===== dv/dee_top_asserts.sv
/*
 checker for dee_top: bus answer timing, zero fields on reads, sticky irq.
 assumes it is bound onto dee_top and sees only its ports.
*/
`timescale 1ns/10ps
module dee_top_asserts
   import dee_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
)(
   // clock and resets
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wdt_rst_i,
   input wire logic        por_i,
   // wishbone
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        irq_o
);
   // ****************************************************
   // helpers
   // ****************************************************
   logic rst_any;
   logic rd_ack;
   logic irq_w;
   assign rst_any = rst_i | wdt_rst_i | por_i;
   assign rd_ack  = ack_o & ~we_i;
   // a write to clear or enable is the only legal way to drop irq
   assign irq_w   = cyc_i & stb_i & we_i & (adr_i == OFS_IRQ_CLR | adr_i == OFS_IRQ_EN);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_any);
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_pulse;
      ack_o ##1 !ack_o;
   endsequence
   property p_ack;
      s_take |=> s_pulse;
   endproperty
   property p_unlock;
      rd_ack && adr_i == OFS_UNLOCK |-> dat_o == 32'h0;
   endproperty
   property p_unmapped;
      rd_ack && adr_i > OFS_IRQ_EN |-> dat_o == 32'h0;
   endproperty
   property p_data;
      rd_ack && adr_i == OFS_DATA |-> dat_o[31:8] == 24'h0;
   endproperty
   property p_addr_hi;
      rd_ack && adr_i == OFS_ADDR_HI |-> dat_o[31:2] == 30'h0;
   endproperty
   property p_ctrl;
      rd_ack && adr_i == OFS_CTRL |-> dat_o[31:4] == 28'h0;
   endproperty
   property p_sticky;
      $fell(irq_o) |-> $past(irq_w) || $past(irq_w, 2);
   endproperty
   property p_reset;
      disable iff (1'b0) rst_any |=> !ack_o && dat_o == 32'h0 && !irq_o;
   endproperty
   a_ack:      assert property (p_ack) else $error("bus answer not a single cycle");
   a_unlock:   assert property (p_unlock) else $error("unlock read not zero");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_data:     assert property (p_data) else $error("data read wider than byte");
   a_addr_hi:  assert property (p_addr_hi) else $error("high address over two bits");
   a_ctrl:     assert property (p_ctrl) else $error("control upper bits set");
   a_sticky:   assert property (p_sticky) else $error("irq dropped on its own");
   a_reset:    assert property (p_reset) else $error("outputs live in reset");
endmodule // dee_top_asserts

bind dee_top dee_top_asserts #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_chk (.clk_i(clk_i),
   .rst_i(rst_i), .wdt_rst_i(wdt_rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .irq_o(irq_o));

// ===== dv/data_eeprom_access_test.sv
/*
 testbench for dee_top: wishbone tasks, unlocked writes, reads, aborts, irq.
 assumes a short write time through WRITE_CYCLES_P.
*/
`timescale 1ns/10ps
module data_eeprom_access_test;
   import dee_pkg::*;
   localparam int unsigned WC = 20;
   logic        clk_i    = 1'b0;
   logic [2:0]  rv       = 3'b101; // por, watchdog, master clear
   logic        cyc      = 1'b0;
   logic        we       = 1'b0;
   logic [7:0]  adr      = 8'h00;
   logic [31:0] wd       = 32'h0;
   logic [31:0] rdat;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        irq_o;
   logic [9:0]  ta [3]   = '{10'h3FF, 10'h000, 10'h3FF};
   logic [7:0]  td [3]   = '{8'h5A, 8'hC3, 8'hA5};
   int          failures = 0;
   int          checked  = 0;
   int          cycles   = 0;
   int          n;
   always #25 clk_i = ~clk_i;
   dee_top #(.WRITE_CYCLES_P(WC)) dut (.clk_i(clk_i), .rst_i(rv[0]), .wdt_rst_i(rv[1]),
      .por_i(rv[2]), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(4'hF),
      .dat_i(wd), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));
   // ****************************************************
   // tasks
   // ****************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // waits for ack with no limit of its own; the hang guard ends a stuck run
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      we  <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task automatic irq(input logic [31:0] e);
      @(posedge clk_i);
      chk(32'(irq_o), e);
   endtask
   task automatic unlock();
      bus(1'b1, OFS_UNLOCK, 32'(KEY_FIRST));
      bus(1'b1, OFS_UNLOCK, 32'(KEY_SECOND));
   endtask
   task automatic start(input logic [9:0] a, input logic [7:0] d);
      bus(1'b1, OFS_ADDR_LO, 32'(a[7:0]));
      bus(1'b1, OFS_ADDR_HI, 32'(a[9:8]));
      bus(1'b1, OFS_DATA, 32'(d));
      bus(1'b1, OFS_CTRL, 32'h4);
      unlock();
      bus(1'b1, OFS_CTRL, 32'h6);
   endtask
   task automatic pulse(input int k);
      @(posedge clk_i);
      rv[k] <= 1'b1;
      repeat (2) @(posedge clk_i);
      rv[k] <= 1'b0;
   endtask
   task automatic results();
      if (failures == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         results();
      end
   end
   // ****************************************************
   // sequence
   // ****************************************************
   initial begin
      repeat (8) @(posedge clk_i);
      rv <= 3'b000;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_UNLOCK, 32'h0);
      rd(8'h20, 32'h0);
      unlock();
      bus(1'b1, OFS_CTRL, 32'h2);
      rd(OFS_CTRL, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h4);
      bus(1'b1, OFS_UNLOCK, 32'(KEY_FIRST));
      bus(1'b1, OFS_DATA, 32'h0);
      bus(1'b1, OFS_UNLOCK, 32'(KEY_SECOND));
      bus(1'b1, OFS_CTRL, 32'h6);
      rd(OFS_CTRL, 32'h4);
      for (int i = 0; i < 3; i++) begin
         start(ta[i], td[i]);
         bus(1'b1, OFS_CTRL, 32'h4);
         bus(1'b1, OFS_DATA, 32'h0);
         rd(OFS_CTRL, 32'h6);
         n = 0;
         do begin
            bus(1'b0, OFS_CTRL, 32'h0);
            n++;
         end while (rdat[BIT_WR] !== 1'b0 && n < 100);
         chk(32'(n > 3), 32'h1);
         rd(OFS_CTRL, 32'h4);
         rd(OFS_DATA, 32'(td[i]));
         rd(OFS_IRQ_ST, 32'h1);
         irq(32'h0);
         bus(1'b1, OFS_IRQ_EN, 32'h1);
         irq(32'h1);
         rd(OFS_IRQ_ST, 32'h1);
         bus(1'b1, OFS_IRQ_CLR, 32'h1);
         irq(32'h0);
         rd(OFS_IRQ_ST, 32'h0);
         bus(1'b1, OFS_IRQ_EN, 32'h0);
      end
      for (int i = 1; i < 3; i++) begin
         bus(1'b1, OFS_ADDR_LO, 32'(ta[i][7:0]));
         bus(1'b1, OFS_ADDR_HI, 32'(ta[i][9:8]));
         bus(1'b1, OFS_CTRL, 32'h1);
         rd(OFS_CTRL, 32'h0);
         rd(OFS_DATA, 32'(td[i]));
      end
      for (int k = 0; k < 2; k++) begin
         start(10'h155, 8'h3C);
         pulse(k);
         rd(OFS_CTRL, 32'h8);
         rd(OFS_DATA, 32'h0);
         rd(OFS_ADDR_LO, 32'h0);
         rd(OFS_ADDR_HI, 32'h0);
         pulse(2);
         rd(OFS_CTRL, 32'h0);
      end
      results();
   end
endmodule // data_eeprom_access_test
